//--- dv/adcsb_core_model.sv
`timescale 1ns/1ps
module adcsb_core_model
(
    // bench control
    input wire logic pclk,
    input wire logic go,
    input wire logic [3:0] n_seq,
    output logic busy,
    // converter side
    input wire adcsb_pkg::adcsb_core_cfg_t core_cfg,
    output adcsb_pkg::adcsb_result_t core_result,
    output logic sample_start
);
    import adcsb_pkg::*;
    logic [7:0] cnt = 8'h0;
    logic m;
    initial
    begin
        busy = 1'b0;
        sample_start = 1'b0;
        core_result = '0;
    end
    // two samples a sequence; the mux in use is folded into each word
    always
    begin
        @(posedge pclk);
        if (go === 1'b1)
        begin
            busy <= 1'b1;
            for (int s = 0; s < n_seq; s++)
                for (int w = 0; w < 2; w++)
                begin
                    @(posedge pclk);
                    sample_start <= 1'b1;
                    m = core_cfg.use_second_mux;
                    @(posedge pclk);
                    sample_start <= 1'b0;
                    @(posedge pclk);
                    core_result <= '{1'b1, w == 1, {m, 7'h0, cnt}};
                    @(posedge pclk);
                    // idle bus shows the inverse so a stale word is never taken
                    core_result <= '{1'b0, 1'b0, ~{m, 7'h0, cnt}};
                    cnt = cnt + 8'h1;
                end
            busy <= 1'b0;
        end
    end
endmodule : adcsb_core_model

//--- dv/adcsb_top_asserts.sv
`timescale 1ns/1ps
module adcsb_top_asserts
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core and interrupt
    input wire adcsb_pkg::adcsb_result_t core_result,
    input wire logic sample_start,
    input wire adcsb_pkg::adcsb_core_cfg_t core_cfg,
    input wire logic irq
);
    import adcsb_pkg::*;
    logic alt_ff;
    logic wr_ctrl;
    assign wr_ctrl = psel && !penable && pwrite && clk_en && paddr == ADCSB_OFF_CTRL2;
    // mirror of the alternate bit, the register itself is not visible here
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            alt_ff <= 1'b0;
        else if (wr_ctrl)
            alt_ff <= pwdata[ADCSB_POS_ALT];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && !penable && clk_en |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_pulse; pready && clk_en |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_ref_ext; wr_ctrl && pwdata[15:13] == 3'h1 |-> ##[1:2] core_cfg[3:2] == 2'b10; endproperty
    a_ref_ext: assert property (p_ref_ext) else $error("wrong reference routing");
    property p_ref_high; wr_ctrl && pwdata[15] |-> ##[1:2] core_cfg[3:2] == 2'b00; endproperty
    a_ref_high: assert property (p_ref_high) else $error("upper codes not internal");
    property p_scan; wr_ctrl && pwdata[10] |-> ##[1:2] core_cfg.first_mux_scan_enable; endproperty
    a_scan: assert property (p_scan) else $error("scan enable not forwarded");
    property p_unimpl;
        pready && !pwrite && paddr == ADCSB_OFF_CTRL2 |-> (prdata & 32'hffff0b40) == 32'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused control bits not zero");
    property p_alt_off; !alt_ff && sample_start |-> ##2 !core_cfg.use_second_mux; endproperty
    a_alt_off: assert property (p_alt_off) else $error("second mux used");
    property p_alt_on;
        alt_ff && sample_start && clk_en && !wr_ctrl |-> ##[1:2] $changed(core_cfg.use_second_mux);
    endproperty
    a_alt_on: assert property (p_alt_on) else $error("mux did not alternate");
endmodule : adcsb_top_asserts

bind adcsb_top adcsb_top_asserts adcsb_top_asserts_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .core_result, .sample_start, .core_cfg, .irq);

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
    import adcsb_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    adcsb_result_t core_result;
    logic sample_start;
    adcsb_core_cfg_t core_cfg;
    logic irq;
    logic go = 1'b0;
    logic [3:0] n_seq = 4'h0;
    logic busy;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int compares = 0;
    always #25 pclk = ~pclk;
    adcsb_top adcsb_top_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_result, .sample_start, .core_cfg, .irq);
    adcsb_core_model adcsb_core_model_i (.pclk, .go, .n_seq, .busy, .core_cfg, .core_result, .sample_start);
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task automatic run(input logic [3:0] n);
        n_seq <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy !== 1'b0) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask : run
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({27'h0, core_cfg, irq}, 32'h0);
        rd(ADCSB_OFF_CTRL2, 32'h0);
        rd(ADCSB_OFF_STAT, 32'h0);
        rd(ADCSB_OFF_MASK, 32'h0);
        apb(1'b0, 12'h010, 32'hffffffff);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, ADCSB_OFF_CTRL2, 32'hefff);
        rd(ADCSB_OFF_CTRL2, 32'he43f);
        for (int v = 0; v < 8; v++)
        begin
            apb(1'b1, ADCSB_OFF_CTRL2, {16'h0, 3'(v), 2'b00, v[0], 10'h0});
            chk(32'(core_cfg), {28'h0, v == 1 || v == 3, v == 2 || v == 3, v[0], 1'b0});
        end
        apb(1'b1, ADCSB_OFF_MASK, 32'h1);
        // three sequences an interrupt, split buffer, alternating mux
        apb(1'b1, ADCSB_OFF_CTRL2, 32'h000b);
        run(4'h2);
        chk(32'(irq), 32'h0);
        run(4'h1);
        chk(32'(irq), 32'h1);
        rd(ADCSB_OFF_STAT, 32'h3);
        rd(ADCSB_OFF_CTRL2, 32'h008b);
        for (int i = 0; i < 6; i++)
            rd(ADCSB_OFF_RESULT + 12'(4 * i), {16'h0, i[0], 7'h0, 8'(i)});
        apb(1'b1, ADCSB_OFF_STAT, 32'h3);
        chk(32'(irq), 32'h0);
        apb(1'b1, ADCSB_OFF_MASK, 32'h0);
        run(4'h3);
        chk(32'(irq), 32'h0);
        rd(ADCSB_OFF_CTRL2, 32'h000b);
        for (int i = 6; i < 12; i++)
            rd(ADCSB_OFF_RESULT + 12'(4 * i + 8), {16'h0, i[0], 7'h0, 8'(i)});
        apb(1'b1, ADCSB_OFF_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b1, ADCSB_OFF_STAT, 32'h3);
        // single buffer, every sequence, first mux only
        apb(1'b1, ADCSB_OFF_CTRL2, 32'h0000);
        run(4'h1);
        chk(32'(irq), 32'h1);
        rd(ADCSB_OFF_RESULT, 32'h000c);
        rd(ADCSB_OFF_RESULT + 12'h4, 32'h000d);
        // split rewritten while the upper half fills: the flag returns with the pointer
        apb(1'b1, ADCSB_OFF_CTRL2, 32'h0003);
        run(4'h1);
        rd(ADCSB_OFF_CTRL2, 32'h0083);
        apb(1'b1, ADCSB_OFF_CTRL2, 32'h0002);
        rd(ADCSB_OFF_CTRL2, 32'h0002);
        // clock enable low: words and sequences pass unseen
        apb(1'b1, ADCSB_OFF_STAT, 32'h3);
        clk_en <= 1'b0;
        run(4'h1);
        clk_en <= 1'b1;
        rd(ADCSB_OFF_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        rd(ADCSB_OFF_RESULT, 32'h000e);
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end
endmodule : tb

//--- hw/adcsb_pkg.sv
package adcsb_pkg;

    // register word offsets (byte addresses)
    localparam logic [11:0] ADCSB_OFF_CTRL2 = 12'h000;
    localparam logic [11:0] ADCSB_OFF_STAT = 12'h004;
    localparam logic [11:0] ADCSB_OFF_MASK = 12'h008;
    localparam logic [11:0] ADCSB_OFF_RESULT = 12'h040;

    // control register field positions
    localparam int ADCSB_POS_REF = 13;
    localparam int ADCSB_POS_RSVD = 12;
    localparam int ADCSB_POS_SCAN = 10;
    localparam int ADCSB_POS_HALF = 7;
    localparam int ADCSB_POS_SPI = 2;
    localparam int ADCSB_POS_SPLIT = 1;
    localparam int ADCSB_POS_ALT = 0;

    // writable bits of the control register: 15-13, 12, 10, 5-0
    localparam logic [15:0] ADCSB_CTRL_WMASK = 16'hf43f;
    localparam logic [15:0] ADCSB_CTRL_RESET = 16'h0000;

    // status / mask layout
    localparam int ADCSB_EV_SEQ = 0;
    localparam int ADCSB_EV_HALF = 1;
    localparam int ADCSB_NUM_EV = 2;
    localparam logic [1:0] ADCSB_EV_RESET = 2'h0;

    localparam int ADCSB_WORDS = 16;
    localparam logic [3:0] ADCSB_HALF_FIRST_TOP = 4'h7;

    typedef enum logic [1:0] {
        ADCSB_REF_INT_INT,
        ADCSB_REF_EXT_INT,
        ADCSB_REF_INT_EXT,
        ADCSB_REF_EXT_EXT
    } adcsb_ref_t;

    // settings steered to the analog core
    typedef struct packed {
        logic ref_pos_external;
        logic ref_neg_external;
        logic first_mux_scan_enable;
        logic use_second_mux;
    } adcsb_core_cfg_t;

    // one finished conversion from the core
    typedef struct packed {
        logic valid;
        logic sequence_end;
        logic [15:0] data;
    } adcsb_result_t;

endpackage : adcsb_pkg

//--- hw/adcsb_top.sv
`timescale 1ns/1ps
module adcsb_top
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog core
    input wire adcsb_pkg::adcsb_result_t core_result,
    input wire logic sample_start,
    output adcsb_pkg::adcsb_core_cfg_t core_cfg,
    // interrupt
    output logic irq
);
    import adcsb_pkg::*;

    logic [15:0] ctrl_ff;
    logic [15:0] mem_ff [ADCSB_WORDS];
    logic [3:0] wr_ptr_ff;
    logic [3:0] seq_cnt_ff;
    logic half_ff;
    logic alt_ff;
    logic [ADCSB_NUM_EV-1:0] stat_ff;
    logic [ADCSB_NUM_EV-1:0] mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    adcsb_core_cfg_t cfg_ff;

    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic is_result;
    logic mapped;
    logic ctrl_wr;
    logic seq_done;
    logic interval_hit;
    logic half_wrap;
    logic [3:0] nxt_wr_ptr;
    logic [ADCSB_NUM_EV-1:0] events;
    logic [31:0] nxt_prdata;
    logic [15:0] ctrl_view;
    logic [3:0] interval;

    // the slave answers one cycle after setup; access ends on that registered pready
    assign setup = clk_en && psel && !penable;
    assign wr_acc = setup && pwrite;
    assign rd_acc = setup && !pwrite;
    assign is_result = (paddr[11:6] == ADCSB_OFF_RESULT[11:6]) && (paddr[1:0] == 2'h0);
    assign mapped = is_result || paddr == ADCSB_OFF_CTRL2 || paddr == ADCSB_OFF_STAT
        || paddr == ADCSB_OFF_MASK;
    assign ctrl_wr = wr_acc && paddr == ADCSB_OFF_CTRL2;
    assign interval = ctrl_ff[ADCSB_POS_SPI +: 4];

    // the 4-bit pointer, the 2-bit status read-back and the hardware-owned half bit rely on these
    if (ADCSB_WORDS != 16)
    begin : g_bad_words
        $error("result buffer depth must be 16 words");
    end
    if (ADCSB_NUM_EV != 2)
    begin : g_bad_events
        $error("status layout must hold two events");
    end
    if (ADCSB_CTRL_WMASK[ADCSB_POS_HALF] != 1'b0)
    begin : g_bad_wmask
        $error("half status bit must not be writable");
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            if (rd_acc)
            begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // unimplemented bits never store, so they read zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= ADCSB_CTRL_RESET;
        end
        else if (clk_en && ctrl_wr)
        begin
            ctrl_ff <= pwdata[15:0] & ADCSB_CTRL_WMASK;
        end
    end

    // the half flag lives outside ctrl_ff since hardware owns it
    always_comb
    begin
        ctrl_view = ctrl_ff;
        ctrl_view[ADCSB_POS_HALF] = half_ff;
    end

    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (is_result)
        begin
            nxt_prdata = {16'h0000, mem_ff[paddr[5:2]]};
        end
        else if (paddr == ADCSB_OFF_CTRL2)
        begin
            nxt_prdata = {16'h0000, ctrl_view};
        end
        else if (paddr == ADCSB_OFF_STAT)
        begin
            nxt_prdata = {30'h0, stat_ff};
        end
        else if (paddr == ADCSB_OFF_MASK)
        begin
            nxt_prdata = {30'h0, mask_ff};
        end
    end

    // result buffer fill
    assign seq_done = core_result.valid && core_result.sequence_end;
    assign interval_hit = seq_done && seq_cnt_ff == interval;

    // split mode wraps each half at its own eighth word
    always_comb
    begin
        nxt_wr_ptr = wr_ptr_ff;
        half_wrap = 1'b0;
        if (core_result.valid)
        begin
            if (interval_hit)
            begin
                if (ctrl_ff[ADCSB_POS_SPLIT])
                begin
                    nxt_wr_ptr = half_ff ? 4'h0 : 4'h8;
                    half_wrap = 1'b1;
                end
                else
                begin
                    nxt_wr_ptr = 4'h0;
                end
            end
            else
            begin
                nxt_wr_ptr = wr_ptr_ff + 4'h1;
                if (ctrl_ff[ADCSB_POS_SPLIT] && wr_ptr_ff[2:0] == ADCSB_HALF_FIRST_TOP[2:0])
                begin
                    nxt_wr_ptr = {wr_ptr_ff[3], 3'h0};
                end
            end
        end
    end

    always_ff @(posedge pclk)
    begin
        if (clk_en && core_result.valid)
        begin
            mem_ff[wr_ptr_ff] <= core_result.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            // any control write sends the fill back to word 0, so the flag must follow it
            if (ctrl_wr)
            begin
                half_ff <= 1'b0;
            end
            else if (half_wrap)
            begin
                half_ff <= !half_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            if (ctrl_wr)
            begin
                wr_ptr_ff <= 4'h0;
            end
            else
            begin
                wr_ptr_ff <= nxt_wr_ptr;
            end
        end
    end

    // sequence counter for the interrupt interval
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_cnt_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            if (ctrl_wr || interval_hit)
            begin
                seq_cnt_ff <= 4'h0;
            end
            else if (seq_done)
            begin
                seq_cnt_ff <= seq_cnt_ff + 4'h1;
            end
        end
    end

    // mux alternation; restarts on first mux whenever control is rewritten
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alt_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ctrl_wr || !ctrl_ff[ADCSB_POS_ALT])
            begin
                alt_ff <= 1'b0;
            end
            else if (sample_start)
            begin
                alt_ff <= !alt_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff <= '0;
        end
        else if (clk_en)
        begin
            case (adcsb_ref_t'(ctrl_ff[ADCSB_POS_REF +: 2]))
                ADCSB_REF_EXT_INT: cfg_ff.ref_pos_external <= !ctrl_ff[ADCSB_POS_REF+2];
                ADCSB_REF_EXT_EXT: cfg_ff.ref_pos_external <= !ctrl_ff[ADCSB_POS_REF+2];
                default: cfg_ff.ref_pos_external <= 1'b0;
            endcase
            case (adcsb_ref_t'(ctrl_ff[ADCSB_POS_REF +: 2]))
                ADCSB_REF_INT_EXT: cfg_ff.ref_neg_external <= !ctrl_ff[ADCSB_POS_REF+2];
                ADCSB_REF_EXT_EXT: cfg_ff.ref_neg_external <= !ctrl_ff[ADCSB_POS_REF+2];
                default: cfg_ff.ref_neg_external <= 1'b0;
            endcase
            cfg_ff.first_mux_scan_enable <= ctrl_ff[ADCSB_POS_SCAN];
            cfg_ff.use_second_mux <= ctrl_ff[ADCSB_POS_ALT] && alt_ff;
        end
    end

    // interrupt status: set wins over write-one-to-clear
    assign events[ADCSB_EV_SEQ] = interval_hit;
    assign events[ADCSB_EV_HALF] = half_wrap;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_ff <= ADCSB_EV_RESET;
        end
        else if (clk_en)
        begin
            if (wr_acc && paddr == ADCSB_OFF_STAT)
            begin
                stat_ff <= (stat_ff & ~pwdata[ADCSB_NUM_EV-1:0]) | events;
            end
            else
            begin
                stat_ff <= stat_ff | events;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_ff <= ADCSB_EV_RESET;
        end
        else if (clk_en && wr_acc && paddr == ADCSB_OFF_MASK)
        begin
            mask_ff <= pwdata[ADCSB_NUM_EV-1:0];
        end
    end

    // one cycle behind status so the pin comes straight from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign core_cfg = cfg_ff;

endmodule : adcsb_top
